// >>> ipp_core_model.sv
// Partner model: processor core side driving strobes and port data
`timescale 1ns/1ps
module ipp_core_model
(
   input  wire logic   core_clk,
   output logic        ale_core,
   output logic        program_fetch_strobe_core,
   output logic [7:0]  port0_core,
   output logic        port0_core_oe,
   output logic [7:0]  port2_core,
   output logic [7:0]  port2_addr,
   output logic [7:0]  port13_core_a,
   output logic [7:0]  port13_core_b
);
   logic [7:0] cnt_reg = 8'h00;
   logic [7:0] cnt_next;
   // Values move every cycle so a leak past a low-power hold shows at once
   always_comb
   begin
      cnt_next = cnt_reg + 8'h01;
   end
   always_ff @(posedge core_clk)
   begin
      cnt_reg <= cnt_next;
   end
   assign ale_core      = cnt_reg[0];
   assign program_fetch_strobe_core     = ~cnt_reg[0];
   assign port0_core    = cnt_reg ^ 8'hA5;
   assign port0_core_oe = 1'h1;
   assign port2_core    = ~cnt_reg;
   assign port2_addr    = cnt_reg + 8'h40;
   assign port13_core_a = cnt_reg;
   assign port13_core_b = {cnt_reg[3:0], cnt_reg[7:4]};
endmodule : ipp_core_model

// >>> ipp_ctrl.sv
// Module: interrupt priority resolver and idle / power-down controller
// Operation
// - Seven sources: two pins, three timers, serial, array
// - Per-source enable plus global enable bit
// - High and low bits give four levels
// - Equal levels resolve in fixed source order
// - Counter array vectors to 0033H
// - Priority registers share one seven-bit map
// - Low priority register resets to zero
// - High priority register resets zero, top unused
// - Idle bit write ends instruction execution
// - Idle gates CPU clock, peripherals keep running
// - Idle holds ports, strobes held high; with ext_mem_mode port 0 floats and port 2 follows port2_addr
// - Enabled interrupt clears idle bit, serviced
// - Two user flags keep written values
// - Power-down stops oscillator, state retained
// - Only reset or enabled pin ends power-down
// - Pin low restarts oscillator, high completes
// - First released pin completes, higher priority served
// - Return resumes after power-down instruction
// - Reset clears registers, pin wake keeps them
// - Both bits set follow power-down exit
// - Port 0 drives only zeros in low power
`timescale 1ns/1ps
module ipp_ctrl
   import ipp_pkg::*;
#(
   parameter int NSRC = NUM_SRC
)
(
   input  wire logic              core_clk,
   input  wire logic              resetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [NSRC-1:0]   src_req,
   input  wire logic              ext_irq_pin_a,
   input  wire logic              ext_irq_pin_b,
   input  wire logic              ext_mem_mode,
   input  wire logic              irq_ack,
   output logic                   irq_valid,
   output logic      [15:0]       irq_vector,
   output logic      [1:0]        irq_level,
   output logic                   cpu_clk_en,
   output logic                   osc_run,
   output logic                   ale_out,
   output logic                   program_fetch_strobe,
   input  wire logic              ale_core,
   input  wire logic              program_fetch_strobe_core,
   input  wire logic [7:0]        port0_core,
   input  wire logic              port0_core_oe,
   input  wire logic [7:0]        port2_core,
   input  wire logic [7:0]        port2_addr,
   input  wire logic [7:0]        port13_core_a,
   input  wire logic [7:0]        port13_core_b,
   output logic      [7:0]        port0_out,
   output logic      [7:0]        port0_oe,
   output logic      [7:0]        port1_out,
   output logic      [7:0]        port2_out,
   output logic      [7:0]        port3_out
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0]   priority_high_reg, priority_high_next;
   logic [7:0]   priority_low_reg, priority_low_next;
   logic [7:0]   enable_reg, enable_next;
   logic [3:0]   power_control_reg, power_control_next;
   ipp_mode_type mode_reg, mode_next;
   logic [7:0]   p0_hold_reg, p0_hold_next;
   logic [7:0]   p1_hold_reg, p1_hold_next;
   logic [7:0]   p2_hold_reg, p2_hold_next;
   logic [7:0]   p3_hold_reg, p3_hold_next;
   logic [1:0]   pins_low_reg, pins_low_next;

   logic         wr_en;
   logic [NSRC-1:0] active;
   logic [1:0]   best_lvl;
   int           best_idx;
   logic [1:0]   pin_wake_en;
   logic         any_irq;
   logic         clr_idle;
   logic         clr_pd;
   logic [1:0]   src_lvl [NSRC];

   function automatic logic [1:0] src_level(input logic [7:0] hi, input logic [7:0] lo,
                                            input int idx);
      src_level = {hi[idx], lo[idx]};
   endfunction : src_level

   function automatic logic [15:0] src_vector(input int idx);
      unique case (idx)
         SRC_EXT0: src_vector = VEC_EXT0;
         SRC_TMR0: src_vector = VEC_TMR0;
         SRC_EXT1: src_vector = VEC_EXT1;
         SRC_TMR1: src_vector = VEC_TMR1;
         SRC_SER:  src_vector = VEC_SER;
         SRC_TMR2: src_vector = VEC_TMR2;
         default:  src_vector = VEC_CA;
      endcase
   endfunction : src_vector

   assign wr_en   = psel && penable && pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   // ----------------------------------------------------------------
   // Priority resolution
   // ----------------------------------------------------------------
   // Sources arrive as levels from the peripherals (pins already decoded)
   assign active = src_req & enable_reg[NSRC-1:0] & {NSRC{enable_reg[EN_GLOBAL_BIT]}};

   // Per-source level, shared by the scan below
   generate
      for (genvar g = 0; g < NSRC; g++)
      begin : g_level
         assign src_lvl[g] = src_level(priority_high_reg, priority_low_reg, g);
      end
   endgenerate

   always_comb
   begin
      best_lvl = 2'b00;
      best_idx = -1;
      // Scan from last to first so an equal level keeps the earlier source
      for (int i = NSRC - 1; i >= 0; i--)
      begin
         if (active[i] && (best_idx < 0 || src_lvl[i] >= best_lvl))
         begin
            best_lvl = src_lvl[i];
            best_idx = i;
         end
      end
   end

   assign any_irq = (best_idx >= 0);
   // Pin wake only if that pin's enable and global enable are set
   assign pin_wake_en = {enable_reg[SRC_EXT1], enable_reg[SRC_EXT0]}
                        & {2{enable_reg[EN_GLOBAL_BIT]}};

   // Request is withheld only while in power-down; it shows again once wake starts
   assign irq_valid  = any_irq && (mode_reg != IPP_PD);
   assign irq_vector = any_irq ? src_vector(best_idx) : 16'h0000;
   assign irq_level  = best_lvl;

   // ----------------------------------------------------------------
   // Mode sequencing
   // ----------------------------------------------------------------
   // Entry waits one edge after the write that sets a request bit, so
   // the requesting access always completes before the core stops
   always_comb
   begin
      mode_next     = mode_reg;
      pins_low_next = pins_low_reg;
      clr_idle      = 1'b0;
      clr_pd        = 1'b0;
      unique case (mode_reg)
         IPP_RUN:
         begin
            if (power_control_reg[PWR_PD_BIT])
               mode_next = IPP_PD;
            else if (power_control_reg[PWR_IDLE_BIT])
               mode_next = IPP_IDLE;
         end
         IPP_IDLE:
         begin
            // Any enabled request ends idle; the core then vectors normally
            if (any_irq)
            begin
               clr_idle  = 1'b1;
               mode_next = IPP_RUN;
            end
         end
         IPP_PD:
         begin
            // Only the two enabled pins are watched; other sources stay masked
            pins_low_next = {~ext_irq_pin_b, ~ext_irq_pin_a} & pin_wake_en;
            if (|pins_low_reg)
               mode_next = IPP_WAKE;
         end
         IPP_WAKE:
         begin
            // Oscillator running; finish once any held pin returns high
            if (|(pins_low_reg & {ext_irq_pin_b, ext_irq_pin_a}))
            begin
               clr_idle      = 1'b1;
               clr_pd        = 1'b1;
               pins_low_next = 2'b00;
               mode_next     = IPP_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         // Reset ends any mode, including an idle or power-down in progress
         mode_reg     <= IPP_RUN;
         pins_low_reg <= 2'b00;
      end
      else
      begin
         mode_reg     <= mode_next;
         pins_low_reg <= pins_low_next;
      end
   end

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   always_comb
   begin
      priority_high_next = priority_high_reg;
      priority_low_next  = priority_low_reg;
      enable_next        = enable_reg;
      power_control_next = power_control_reg;
      if (wr_en)
      begin
         unique case (paddr)
            ADDR_PRIO_HIGH: priority_high_next = {1'b0, pwdata[PRIO_USED_MSB:0]};
            ADDR_PRIO_LOW:  priority_low_next  = {1'b0, pwdata[PRIO_USED_MSB:0]};
            ADDR_ENABLE:    enable_next        = pwdata[7:0];
            ADDR_POWER:     power_control_next = pwdata[3:0];
            default:        ;
         endcase
      end
      // Hardware clear wins over a write landing in the same cycle
      if (clr_idle)
         power_control_next[PWR_IDLE_BIT] = 1'b0;
      if (clr_pd)
         power_control_next[PWR_PD_BIT] = 1'b0;
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         // Every register returns to its reset value (RAM lies elsewhere)
         priority_high_reg <= PRIO_RESET;
         priority_low_reg  <= PRIO_RESET;
         enable_reg        <= ENABLE_RESET;
         power_control_reg <= POWER_RESET;
      end
      else
      begin
         priority_high_reg <= priority_high_next;
         priority_low_reg  <= priority_low_next;
         enable_reg        <= enable_next;
         power_control_reg <= power_control_next;
      end
   end

   // ----------------------------------------------------------------
   // Port snapshot
   // ----------------------------------------------------------------
   // Levels are frozen on the edge that enters a low-power mode, so
   // later core activity reaches no pin except port 2, which follows port2_addr in idle with ext_mem_mode
   always_comb
   begin
      p0_hold_next = p0_hold_reg;
      p1_hold_next = p1_hold_reg;
      p2_hold_next = p2_hold_reg;
      p3_hold_next = p3_hold_reg;
      if ((mode_reg == IPP_RUN) &&
          (power_control_reg[PWR_PD_BIT] || power_control_reg[PWR_IDLE_BIT]))
      begin
         p0_hold_next = port0_core;
         p1_hold_next = port13_core_a;
         p2_hold_next = port2_core;
         p3_hold_next = port13_core_b;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         p0_hold_reg <= 8'h00;
         p1_hold_reg <= 8'h00;
         p2_hold_reg <= 8'h00;
         p3_hold_reg <= 8'h00;
      end
      else
      begin
         p0_hold_reg <= p0_hold_next;
         p1_hold_reg <= p1_hold_next;
         p2_hold_reg <= p2_hold_next;
         p3_hold_reg <= p3_hold_next;
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always_comb
   begin
      prdata = 32'h0000_0000;
      if (psel && !pwrite)
      begin
         unique case (paddr)
            ADDR_PRIO_HIGH: prdata = {24'h000000, priority_high_reg};
            ADDR_PRIO_LOW:  prdata = {24'h000000, priority_low_reg};
            ADDR_ENABLE:    prdata = {24'h000000, enable_reg};
            ADDR_POWER:     prdata = {28'h0000000, power_control_reg};
            ADDR_STATUS:    prdata = {21'h000000, best_lvl, 1'b0, active, mode_reg[0]};
            default:        prdata = 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Clock gating and pin states
   // ----------------------------------------------------------------
   assign cpu_clk_en = (mode_reg == IPP_RUN);
   assign osc_run    = (mode_reg != IPP_PD);

   always_comb
   begin
      ale_out              = ale_core;
      program_fetch_strobe = program_fetch_strobe_core;
      port0_out            = port0_core;
      port0_oe             = {8{port0_core_oe}};
      port1_out            = port13_core_a;
      port2_out            = port2_core;
      port3_out            = port13_core_b;
      if (mode_reg != IPP_RUN)
      begin
         port0_out = 8'h00;
         port0_oe  = ~p0_hold_reg;
         port1_out = p1_hold_reg;
         port2_out = p2_hold_reg;
         port3_out = p3_hold_reg;
         if (mode_reg == IPP_IDLE)
         begin
            ale_out              = 1'b1;
            program_fetch_strobe = 1'b1;
            if (ext_mem_mode)
            begin
               port0_oe  = 8'h00;
               port2_out = port2_addr;
            end
         end
         else
         begin
            ale_out              = 1'b0;
            program_fetch_strobe = 1'b0;
            if (ext_mem_mode)
               port0_oe = 8'h00;
         end
      end
   end

   // irq_ack is a core handshake; acknowledgement needs no state here
   logic unused_ack;
   assign unused_ack = irq_ack;

endmodule : ipp_ctrl

// >>> ipp_ctrl_asserts.sv
// Checker: port-level assertions for the priority and power mode controller
`timescale 1ns/1ps
module ipp_ctrl_asserts
   import ipp_pkg::*;
#(
   parameter int NSRC = NUM_SRC
)
(
   input wire logic              core_clk,
   input wire logic              resetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [11:0]       paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [NSRC-1:0]   src_req,
   input wire logic              ext_irq_pin_a,
   input wire logic              ext_irq_pin_b,
   input wire logic              irq_valid,
   input wire logic [15:0]       irq_vector,
   input wire logic              cpu_clk_en,
   input wire logic              osc_run,
   input wire logic              ale_out,
   input wire logic              program_fetch_strobe,
   input wire logic [7:0]        port0_out
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   wire pwr_wr = psel && penable && pwrite && (paddr == ADDR_POWER);
   wire pins_hi = ext_irq_pin_a && ext_irq_pin_b;
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_idle_entry: assert property (pwr_wr && pwdata[1:0] == 2'h1 |-> ##2 (!cpu_clk_en && osc_run))
      else $error("idle not entered after idle request");
   a_idle_strobes: assert property (pwr_wr && pwdata[1:0] == 2'h1 |-> ##2 (ale_out && program_fetch_strobe))
      else $error("strobes not high in idle");
   a_pd_entry: assert property (pwr_wr && pwdata[PWR_PD_BIT] |-> ##2 !osc_run)
      else $error("oscillator still running after power-down request");
   a_pd_strobes: assert property (!osc_run |-> !ale_out && !program_fetch_strobe)
      else $error("strobes not low in power-down");
   a_pd_port0: assert property (!osc_run |-> port0_out == 8'h00)
      else $error("port 0 drives a one in power-down");
   a_ca_vector: assert property (irq_valid && src_req == 7'h40 |-> irq_vector == VEC_CA)
      else $error("counter array vector wrong");
   a_pd_stays: assert property (!osc_run && pins_hi && $past(pins_hi) |=> !osc_run)
      else $error("power-down left without a pin request");
   a_idle_exit: assert property (!cpu_clk_en && osc_run && irq_valid && pins_hi |-> ##[1:2] cpu_clk_en)
      else $error("idle not left on enabled request");
endmodule : ipp_ctrl_asserts

bind ipp_ctrl ipp_ctrl_asserts #(.NSRC(NSRC)) ipp_ctrl_asserts_inst (
   .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .src_req(src_req),
   .ext_irq_pin_a(ext_irq_pin_a), .ext_irq_pin_b(ext_irq_pin_b), .irq_valid(irq_valid),
   .irq_vector(irq_vector), .cpu_clk_en(cpu_clk_en), .osc_run(osc_run), .ale_out(ale_out),
   .program_fetch_strobe(program_fetch_strobe), .port0_out(port0_out)
);

// >>> ipp_pkg.sv
// Package: constants for the interrupt priority and power mode controller
package ipp_pkg;
   localparam int NUM_SRC = 7;
   // Source indices in fixed resolution order
   localparam int SRC_EXT0 = 0;
   localparam int SRC_TMR0 = 1;
   localparam int SRC_EXT1 = 2;
   localparam int SRC_TMR1 = 3;
   localparam int SRC_SER  = 4;
   localparam int SRC_TMR2 = 5;
   localparam int SRC_CA   = 6;
   // APB byte addresses (printed offsets 0xB7 and 0xB8 are indices)
   localparam logic [7:0] IDX_PRIO_HIGH = 8'hB7;
   localparam logic [7:0] IDX_PRIO_LOW  = 8'hB8;
   localparam logic [7:0] IDX_ENABLE    = 8'hA8;
   localparam logic [7:0] IDX_POWER     = 8'h87;
   localparam logic [7:0] IDX_STATUS    = 8'hC0;
   localparam logic [11:0] ADDR_PRIO_HIGH = {2'b00, IDX_PRIO_HIGH, 2'b00};
   localparam logic [11:0] ADDR_PRIO_LOW  = {2'b00, IDX_PRIO_LOW, 2'b00};
   localparam logic [11:0] ADDR_ENABLE    = {2'b00, IDX_ENABLE, 2'b00};
   localparam logic [11:0] ADDR_POWER     = {2'b00, IDX_POWER, 2'b00};
   localparam logic [11:0] ADDR_STATUS    = {2'b00, IDX_STATUS, 2'b00};
   localparam logic [7:0] PRIO_RESET = 8'h00;
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [3:0] POWER_RESET = 4'h0;
   // Field positions
   localparam int EN_GLOBAL_BIT = 7;
   localparam int PWR_IDLE_BIT  = 0;
   localparam int PWR_PD_BIT    = 1;
   localparam int PWR_FLAGA_BIT = 2;
   localparam int PWR_FLAGB_BIT = 3;
   localparam int PRIO_USED_MSB = 6;
   // Vector addresses
   localparam logic [15:0] VEC_EXT0 = 16'h0003;
   localparam logic [15:0] VEC_TMR0 = 16'h000B;
   localparam logic [15:0] VEC_EXT1 = 16'h0013;
   localparam logic [15:0] VEC_TMR1 = 16'h001B;
   localparam logic [15:0] VEC_SER  = 16'h0023;
   localparam logic [15:0] VEC_TMR2 = 16'h002B;
   localparam logic [15:0] VEC_CA   = 16'h0033;
   typedef enum logic [1:0]
   {
      IPP_RUN  = 2'b00,
      IPP_IDLE = 2'b01,
      IPP_PD   = 2'b10,
      IPP_WAKE = 2'b11
   } ipp_mode_type;
endpackage : ipp_pkg

// >>> tb_top.sv
// Testbench: register, priority and power mode scenarios for the controller
`timescale 1ns/1ps
module tb_top
   import ipp_pkg::*;
;
   logic        clk, resetn, psel, penable, pwrite, pin_a, pin_b, xmem, ack;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, irq_valid, cpu_en, osc, ale, pfs, ale_c, program_fetch_strobe_c, p0c_oe;
   logic [6:0]  src_req;
   logic [15:0] vec;
   logic [1:0]  lvl;
   logic [7:0]  p0c, p2c, p2a, p13a, p13b, p0o, p0oe, p1o, p2o, p3o;
   int          failures, check_count;
   localparam logic [15:0] VECS [7] = '{VEC_EXT0, VEC_TMR0, VEC_EXT1, VEC_TMR1, VEC_SER,
                                        VEC_TMR2, VEC_CA};
   ipp_ctrl ipp_ctrl_inst (.core_clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .src_req(src_req), .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b),
      .ext_mem_mode(xmem), .irq_ack(ack), .irq_valid(irq_valid), .irq_vector(vec),
      .irq_level(lvl), .cpu_clk_en(cpu_en), .osc_run(osc), .ale_out(ale),
      .program_fetch_strobe(pfs), .ale_core(ale_c), .program_fetch_strobe_core(program_fetch_strobe_c), .port0_core(p0c),
      .port0_core_oe(p0c_oe), .port2_core(p2c), .port2_addr(p2a), .port13_core_a(p13a),
      .port13_core_b(p13b), .port0_out(p0o), .port0_oe(p0oe), .port1_out(p1o),
      .port2_out(p2o), .port3_out(p3o));
   ipp_core_model ipp_core_model_inst (.core_clk(clk), .ale_core(ale_c), .program_fetch_strobe_core(program_fetch_strobe_c),
      .port0_core(p0c), .port0_core_oe(p0c_oe), .port2_core(p2c), .port2_addr(p2a),
      .port13_core_a(p13a), .port13_core_b(p13b));
   initial
   begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic timeout(input string what);
      failures++;
      $display("MISMATCH %s expected 1 seen timeout", what);
      final_report();
   endtask : timeout
   // Holds the whole request until pready is sampled high; read data taken there
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      for (n = 0; n < 9; n++)
      begin
         @(posedge clk);
         if (pready === 1'h1)
            break;
      end
      if (pready !== 1'h1)
         timeout("pready");
      rd = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task automatic wait_hi(input string what, input bit use_osc);
      for (int n = 0; n < 20; n++)
      begin
         @(posedge clk);
         #1;
         if ((use_osc ? osc : cpu_en) === 1'h1)
            return;
      end
      timeout(what);
   endtask : wait_hi
   task automatic prio_case(input logic [7:0] lo, hi, input logic [15:0] v, input logic [1:0] l);
      apb(1'h1, ADDR_PRIO_LOW, {24'h0, lo});
      apb(1'h1, ADDR_PRIO_HIGH, {24'h0, hi});
      #1;
      chk("winner vector", v, vec);
      chk("winner level", l, lvl);
   endtask : prio_case
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs;
      apb(1'h0, ADDR_PRIO_HIGH, 32'h0);
      chk("prio_high reset", 32'h0, rd);
      apb(1'h0, ADDR_PRIO_LOW, 32'h0);
      chk("prio_low reset", 32'h0, rd);
      apb(1'h0, 12'hFFC, 32'h0);
      chk("unmapped read", 32'h0, rd);
      apb(1'h1, ADDR_PRIO_HIGH, 32'hFF);
      apb(1'h0, ADDR_PRIO_HIGH, 32'h0);
      chk("prio_high used bits", 32'h7F, rd);
      apb(1'h1, ADDR_POWER, 32'hC);
      apb(1'h0, ADDR_POWER, 32'h0);
      chk("user flags", 32'hC, rd);
      apb(1'h1, ADDR_PRIO_HIGH, 32'h0);
      $display("test regs done");
   endtask : t_regs
   task automatic t_prio;
      apb(1'h1, ADDR_ENABLE, 32'hFF);
      for (int i = 0; i < 7; i++)
      begin
         @(posedge clk);
         src_req <= 7'h7F << i;
         #1;
         chk("equal level vector", VECS[i], vec);
      end
      @(posedge clk);
      src_req <= 7'h7F;
      prio_case(8'h40, 8'h00, VEC_CA, 2'h1);
      prio_case(8'h40, 8'h20, VEC_TMR2, 2'h2);
      prio_case(8'h50, 8'h30, VEC_SER, 2'h3);
      apb(1'h1, ADDR_ENABLE, 32'h7F);
      #1;
      chk("global disable", 32'h0, irq_valid);
      apb(1'h1, ADDR_ENABLE, 32'hFE);
      src_req <= 7'h01;
      @(posedge clk);
      #1;
      chk("source disable", 32'h0, irq_valid);
      $display("test prio done");
   endtask : t_prio
   task automatic t_idle;
      logic [7:0] p1;
      logic [7:0] p3;
      @(posedge clk);
      src_req <= 7'h00;
      xmem <= 1'h1;
      apb(1'h1, ADDR_ENABLE, 32'h82);
      apb(1'h1, ADDR_POWER, 32'h5);
      // Mode changes on the edge after the write edge
      @(posedge clk);
      #1;
      p1 = p1o;
      p3 = p3o;
      chk("idle cpu clock", 32'h0, cpu_en);
      chk("idle strobes", 32'h3, {ale, pfs});
      chk("idle port0 float", 32'h0, p0oe);
      repeat (3) @(posedge clk);
      #1;
      chk("idle port1 held", p1, p1o);
      chk("idle port3 held", p3, p3o);
      chk("idle port2 address", p2a, p2o);
      @(posedge clk);
      src_req <= 7'h02;
      wait_hi("idle exit", 1'h0);
      apb(1'h0, ADDR_POWER, 32'h0);
      chk("idle bit cleared", 32'h4, rd);
      apb(1'h0, ADDR_STATUS, 32'h0);
      chk("status active", 32'h4, rd);
      $display("test idle done");
   endtask : t_idle
   task automatic t_pd;
      @(posedge clk);
      src_req <= 7'h00;
      xmem <= 1'h0;
      apb(1'h1, ADDR_PRIO_LOW, 32'h2A);
      apb(1'h1, ADDR_ENABLE, 32'h81);
      apb(1'h1, ADDR_POWER, 32'h3);
      @(posedge clk);
      #1;
      chk("pd oscillator", 32'h0, osc);
      chk("pd strobes", 32'h0, {ale, pfs});
      chk("pd port0 zero", 32'h0, p0o);
      @(posedge clk);
      src_req <= 7'h7F;
      pin_b <= 1'h0;
      repeat (4) @(posedge clk);
      #1;
      chk("pd ignores others", 32'h0, {osc, irq_valid});
      @(posedge clk);
      pin_a <= 1'h0;
      wait_hi("oscillator restart", 1'h1);
      chk("wake pending", 32'h0, cpu_en);
      repeat (8) @(posedge clk);
      pin_a <= 1'h1;
      wait_hi("wake complete", 1'h0);
      pin_b <= 1'h1;
      apb(1'h0, ADDR_POWER, 32'h0);
      chk("pd bits cleared", 32'h0, rd);
      apb(1'h0, ADDR_PRIO_LOW, 32'h0);
      chk("pin wake keeps regs", 32'h2A, rd);
      $display("test powerdown done");
   endtask : t_pd
   task automatic t_reset;
      apb(1'h1, ADDR_POWER, 32'h2);
      @(posedge clk);
      resetn <= 1'h0;
      repeat (24) @(posedge clk);
      resetn <= 1'h1;
      #1;
      chk("reset restarts oscillator", 32'h1, osc);
      apb(1'h0, ADDR_PRIO_LOW, 32'h0);
      chk("reset clears prio", 32'h0, rd);
      $display("test reset done");
   endtask : t_reset
   initial
   begin
      {resetn, psel, penable, pwrite, pin_a, pin_b, xmem, ack} = 8'h0C;
      {paddr, pwdata, src_req} = '0;
      failures = 0;
      check_count = 0;
      repeat (10) @(posedge clk);
      resetn <= 1'h1;
      t_regs();
      t_prio();
      t_idle();
      t_pd();
      t_reset();
      final_report();
   end
endmodule : tb_top
